/* File: rtl/eus_params.svh */
// constants of the update sequence controller: codes, resets, fields
`ifndef EUS_PARAMS_SVH
`define EUS_PARAMS_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define EUS_CMD_TEMP_WR 8'h1a
`define EUS_CMD_TEMP_RD 8'h1b
`define EUS_CMD_ACTIVATE 8'h20
`define EUS_CMD_RAM_OPT 8'h21
`define EUS_CMD_STAGE_OPT 8'h22

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EUS_TEMP_RST 12'h7ff
`define EUS_RAM_OPT_RST 8'h00
`define EUS_STAGE_OPT_RST 8'hff

// ------------------------------------------------------------
// ram option plane codes
// ------------------------------------------------------------
`define EUS_PLANE_NORMAL 4'h0
`define EUS_PLANE_BYPASS 4'h4
`define EUS_PLANE_INVERT 4'h8
`define EUS_RED_MSB 7
`define EUS_RED_LSB 4
`define EUS_BW_MSB 3
`define EUS_BW_LSB 0

// ------------------------------------------------------------
// stage option bit positions, also the stage code driven out
// ------------------------------------------------------------
`define EUS_STG_CLK_ON 3'h7
`define EUS_STG_ANA_ON 3'h6
`define EUS_STG_TEMP 3'h5
`define EUS_STG_TABLE 3'h4
`define EUS_STG_DISPLAY 3'h2
`define EUS_STG_ANA_OFF 3'h1
`define EUS_STG_OSC_OFF 3'h0
`define EUS_STAGE_COUNT 3'h7

`endif

/* File: rtl/eus_pkg.sv */
// types of the update sequence controller
`default_nettype none
package eus_pkg;
  typedef enum logic [2:0] {
    EUS_CMD_NONE,
    EUS_CMD_TWR,
    EUS_CMD_TRD,
    EUS_CMD_ROPT,
    EUS_CMD_SOPT
  } eus_cmd_type;

  typedef enum logic [1:0] {
    EUS_SEQ_IDLE,
    EUS_SEQ_SCAN,
    EUS_SEQ_WAIT
  } eus_seq_type;
endpackage
`default_nettype wire

/* File: rtl/eus_plane_map.sv */
// one ram plane mapped through its content option
`default_nettype none
`include "eus_params.svh"
module eus_plane_map
  import eus_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // option and pixel
  input wire logic [3:0] mode,
  input wire logic ram_bit,
  output logic pix_r
);

  // unlisted codes fall back to normal content
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pix_r <= 1'b0;
    end else if (mode == `EUS_PLANE_BYPASS) begin
      pix_r <= 1'b0; // R10
    end else if (mode == `EUS_PLANE_INVERT) begin
      pix_r <= ~ram_bit; // R8 R9
    end else begin
      pix_r <= ram_bit; // R8 R9
    end
  end

  AST_BYPASS_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == `EUS_PLANE_BYPASS |=> !pix_r) // R10
    else $error("bypassed plane pixel not zero");

  AST_INVERT_PIX: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == `EUS_PLANE_INVERT |=> pix_r == !$past(ram_bit)) // R8
    else $error("inverted plane pixel wrong");

endmodule
`default_nettype wire

/* File: rtl/eus_update_ctrl.sv */
// command interpreter and display update sequencer
// Operation
// (R1) command 1a writes temperature: byte one bits 11..4, byte two nibble 3..0
// (R2) command 1b returns temperature as two bytes, low nibble of second zero
// (R3) command 20 without parameter starts the display update sequence
// (R4) the sequence runs stages enabled by the latest command 22 byte
// (R5) busy stays high while the sequence runs, low once finished
// (R6) host sends nothing until busy returns low
// (R7) command 21 takes one ram option byte, reset value 00
// (R8) red plane option in bits 7..4: normal, forced zero, inverted
// (R9) black/white plane option in bits 3..0, same encoding
// (R10) bypass makes every pixel of that plane zero
// (R11) command 22 takes one stage option byte, reset value ff
// (R12) option c7: clock on, analog on, display, analog off, oscillator off
// (R13) option 91: clock on, load waveform table, oscillator off
// (R14) option b1: clock on, load temperature, load table, oscillator off
// (R15) stages run in fixed order, one at a time; busy drops after last
`default_nettype none
`include "eus_params.svh"
module eus_update_ctrl
  import eus_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // received bytes from the serial front end
  input wire logic rx_valid,
  input wire logic rx_is_data,
  input wire logic [7:0] rx_byte,
  // read byte request and answer
  input wire logic rd_req,
  output logic rd_valid_r,
  output logic [7:0] rd_byte_r,
  // stage handshake with analog, table and display units
  output logic stage_go_r,
  output logic [2:0] stage_code_r,
  input wire logic stage_done,
  input wire logic [11:0] sensor_temp,
  output logic clk_en_r,
  output logic analog_en_r,
  output logic busy_r,
  // pixel path
  input wire logic ram_red_bit,
  input wire logic ram_bw_bit,
  output logic red_pix_r,
  output logic bw_pix_r
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  eus_cmd_type cmd_r;
  eus_seq_type seq_r;
  logic pidx_r;
  logic [11:0] temperature_value_r;
  logic [7:0] ram_content_option_r;
  logic [7:0] update_stage_option_r;
  logic [7:0] snap_r;
  logic [2:0] idx_r;
  logic cmd_acc;
  logic data_acc;
  logic act_start;
  logic [2:0] cur_bit;

  // bytes are dropped while busy so a running update is never disturbed
  assign cmd_acc = rx_valid && !rx_is_data && !busy_r; // R6
  assign data_acc = rx_valid && rx_is_data && !busy_r;
  assign act_start = cmd_acc && rx_byte == `EUS_CMD_ACTIVATE; // R3

  function automatic logic [2:0] stage_bit(input logic [2:0] i);
    case (i)
      3'h0: stage_bit = `EUS_STG_CLK_ON;
      3'h1: stage_bit = `EUS_STG_ANA_ON;
      3'h2: stage_bit = `EUS_STG_TEMP;
      3'h3: stage_bit = `EUS_STG_TABLE;
      3'h4: stage_bit = `EUS_STG_DISPLAY;
      3'h5: stage_bit = `EUS_STG_ANA_OFF;
      default: stage_bit = `EUS_STG_OSC_OFF;
    endcase
  endfunction

  assign cur_bit = stage_bit(idx_r); // R15

  // ------------------------------------------------------------
  // command decode and parameter index
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= EUS_CMD_NONE;
      pidx_r <= 1'b0;
    end else if (cmd_acc) begin
      pidx_r <= 1'b0;
      unique case (rx_byte)
        `EUS_CMD_TEMP_WR: cmd_r <= EUS_CMD_TWR;
        `EUS_CMD_TEMP_RD: cmd_r <= EUS_CMD_TRD;
        `EUS_CMD_RAM_OPT: cmd_r <= EUS_CMD_ROPT;
        `EUS_CMD_STAGE_OPT: cmd_r <= EUS_CMD_SOPT;
        default: cmd_r <= EUS_CMD_NONE;
      endcase
    end else if (data_acc || (rd_req && cmd_r == EUS_CMD_TRD)) begin
      pidx_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // temperature register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      temperature_value_r <= `EUS_TEMP_RST;
    end else if (data_acc && cmd_r == EUS_CMD_TWR) begin
      if (!pidx_r) begin
        temperature_value_r[11:4] <= rx_byte; // R1
      end else begin
        temperature_value_r[3:0] <= rx_byte[7:4]; // R1
      end
    end else if (seq_r == EUS_SEQ_WAIT && stage_done &&
                 cur_bit == `EUS_STG_TEMP) begin
      temperature_value_r <= sensor_temp; // R14
    end
  end

  // ------------------------------------------------------------
  // option registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_content_option_r <= `EUS_RAM_OPT_RST; // R7
      update_stage_option_r <= `EUS_STAGE_OPT_RST; // R11
    end else if (data_acc && !pidx_r) begin
      if (cmd_r == EUS_CMD_ROPT) begin
        ram_content_option_r <= rx_byte; // R7
      end
      if (cmd_r == EUS_CMD_SOPT) begin
        update_stage_option_r <= rx_byte; // R11
      end
    end
  end

  // ------------------------------------------------------------
  // read answers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_r <= 1'b0;
      rd_byte_r <= 8'h00;
    end else begin
      rd_valid_r <= rd_req;
      if (rd_req && cmd_r == EUS_CMD_TRD) begin
        if (!pidx_r) begin
          rd_byte_r <= temperature_value_r[11:4]; // R2
        end else begin
          rd_byte_r <= {temperature_value_r[3:0], 4'h0}; // R2
        end
      end else if (rd_req) begin
        rd_byte_r <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // update sequencer
  // ------------------------------------------------------------
  // the option byte is copied at start, so stages follow one setting
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= EUS_SEQ_IDLE;
      idx_r <= 3'h0;
      snap_r <= `EUS_STAGE_OPT_RST;
      busy_r <= 1'b0;
      stage_go_r <= 1'b0;
      stage_code_r <= 3'h0;
    end else begin
      stage_go_r <= 1'b0;
      unique case (seq_r)
        EUS_SEQ_IDLE: begin
          if (act_start) begin
            snap_r <= update_stage_option_r; // R4
            idx_r <= 3'h0;
            busy_r <= 1'b1; // R5
            seq_r <= EUS_SEQ_SCAN; // R3
          end
        end
        EUS_SEQ_SCAN: begin
          if (idx_r == `EUS_STAGE_COUNT) begin
            busy_r <= 1'b0; // R5 R15
            seq_r <= EUS_SEQ_IDLE;
          end else if (snap_r[cur_bit]) begin
            stage_go_r <= 1'b1; // R12 R13 R14
            stage_code_r <= cur_bit;
            seq_r <= EUS_SEQ_WAIT;
          end else begin
            idx_r <= idx_r + 3'h1; // R4
          end
        end
        EUS_SEQ_WAIT: begin
          if (stage_done) begin
            idx_r <= idx_r + 3'h1; // R15
            seq_r <= EUS_SEQ_SCAN;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // clock and analog enables follow completed stages
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_en_r <= 1'b0;
      analog_en_r <= 1'b0;
    end else if (seq_r == EUS_SEQ_WAIT && stage_done) begin
      if (cur_bit == `EUS_STG_CLK_ON) begin
        clk_en_r <= 1'b1; // R12
      end
      if (cur_bit == `EUS_STG_OSC_OFF) begin
        clk_en_r <= 1'b0; // R12
      end
      if (cur_bit == `EUS_STG_ANA_ON) begin
        analog_en_r <= 1'b1; // R12
      end
      if (cur_bit == `EUS_STG_ANA_OFF) begin
        analog_en_r <= 1'b0; // R12
      end
    end
  end

  // ------------------------------------------------------------
  // pixel planes
  // ------------------------------------------------------------
  eus_plane_map u_red (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mode(ram_content_option_r[`EUS_RED_MSB:`EUS_RED_LSB]), // R8
    .ram_bit(ram_red_bit),
    .pix_r(red_pix_r)
  );

  eus_plane_map u_bw (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mode(ram_content_option_r[`EUS_BW_MSB:`EUS_BW_LSB]), // R9
    .ram_bit(ram_bw_bit),
    .pix_r(bw_pix_r)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_activate;
    act_start && seq_r == EUS_SEQ_IDLE;
  endsequence
  sequence s_running;
    busy_r && seq_r == EUS_SEQ_SCAN;
  endsequence

  AST_TEMP_WR_HI: assert property (@(posedge mclk) disable iff (sys_rst)
    data_acc && cmd_r == EUS_CMD_TWR && !pidx_r |=>
    temperature_value_r[11:4] == $past(rx_byte)) // R1
    else $error("temperature high byte not stored");
  AST_TEMP_WR_LO: assert property (@(posedge mclk) disable iff (sys_rst)
    data_acc && cmd_r == EUS_CMD_TWR && pidx_r |=>
    temperature_value_r[3:0] == $past(rx_byte[7:4])) // R1
    else $error("temperature low nibble not stored");
  AST_TEMP_RD: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_req && cmd_r == EUS_CMD_TRD && pidx_r |=>
    rd_valid_r && rd_byte_r[3:0] == 4'h0 &&
    rd_byte_r[7:4] == $past(temperature_value_r[3:0])) // R2
    else $error("temperature second byte wrong");
  AST_ACT_BUSY: assert property (@(posedge mclk) disable iff (sys_rst)
    s_activate |=> s_running) // R3
    else $error("activation did not raise busy");
  AST_STAGE_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
    stage_go_r |-> busy_r && snap_r[stage_code_r]) // R4
    else $error("stage run that was not enabled");

  AST_BUSY_END: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(busy_r) |-> $past(idx_r) == `EUS_STAGE_COUNT &&
    $past(seq_r) == EUS_SEQ_SCAN) // R5
    else $error("busy dropped before last stage");

  AST_RAM_OPT: assert property (@(posedge mclk) disable iff (sys_rst)
    data_acc && cmd_r == EUS_CMD_ROPT && !pidx_r |=>
    ram_content_option_r == $past(rx_byte)) // R7
    else $error("ram option not stored");

  AST_ONE_STAGE: assert property (@(posedge mclk) disable iff (sys_rst)
    stage_go_r |-> seq_r == EUS_SEQ_WAIT ##1 !stage_go_r) // R15
    else $error("stage issued outside wait");

  AST_ENABLES: assert property (@(posedge mclk) disable iff (sys_rst)
    stage_go_r && stage_code_r == `EUS_STG_DISPLAY &&
    snap_r == 8'hc7 |-> clk_en_r && analog_en_r) // R12
    else $error("display stage without clock and analog");

endmodule
`default_nettype wire

/* File: verification/eus_stage_unit_model.sv */
// stage unit model answering each stage start after a set latency
`default_nettype none
module eus_stage_unit_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // stage handshake
  input wire logic stage_go_r,
  input wire logic [3:0] lat,
  output logic stage_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // latency counter
  // ------------------------------------------------------------
  // a stage start restarts the count, so one stage is served at a time
  logic [3:0] cnt_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
      stage_done <= 1'b0;
    end else begin
      stage_done <= 1'b0;
      if (stage_go_r) begin
        cnt_r <= lat;
      end else if (cnt_r > 4'h1) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (cnt_r == 4'h1) begin
        cnt_r <= 4'h0;
        stage_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/epd_update_sequence_ctrl_tb_top.sv */
// testbench of the update sequence controller
`default_nettype none
`include "eus_params.svh"
module epd_update_sequence_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk = 0, sys_rst = 1, rx_valid = 0, rx_is_data = 0, rd_req = 0;
  logic ram_red_bit = 0, ram_bw_bit = 0, stage_done;
  logic [7:0] rx_byte = 8'h00;
  logic [11:0] sensor_temp = 12'habc;
  logic [3:0] lat = 4'h1;
  logic rd_valid_r, stage_go_r, clk_en_r, analog_en_r, busy_r;
  logic red_pix_r, bw_pix_r;
  logic [7:0] rd_byte_r;
  logic [2:0] stage_code_r;
  logic [4:0] seen[$];
  logic [4:0] expq[$];
  int n_mismatch = 0;
  int checked = 0;

  eus_update_ctrl u_eus_update_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_is_data(rx_is_data), .rx_byte(rx_byte),
    .rd_req(rd_req), .rd_valid_r(rd_valid_r), .rd_byte_r(rd_byte_r),
    .stage_go_r(stage_go_r), .stage_code_r(stage_code_r),
    .stage_done(stage_done), .sensor_temp(sensor_temp),
    .clk_en_r(clk_en_r), .analog_en_r(analog_en_r), .busy_r(busy_r),
    .ram_red_bit(ram_red_bit), .ram_bw_bit(ram_bw_bit),
    .red_pix_r(red_pix_r), .bw_pix_r(bw_pix_r));
  eus_stage_unit_model u_eus_stage_unit_model (.mclk(mclk),
    .sys_rst(sys_rst), .stage_go_r(stage_go_r), .lat(lat),
    .stage_done(stage_done));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(string nm, logic [11:0] e, logic [11:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task put(logic d, logic [7:0] b);
    @(negedge mclk);
    rx_valid = 1;
    rx_is_data = d;
    rx_byte = b;
    @(negedge mclk);
    rx_valid = 0;
  endtask

  task rd(logic [7:0] e);
    @(negedge mclk);
    rd_req = 1;
    @(negedge mclk);
    rd_req = 0;
    chk("rd_valid", 12'h1, {11'h0, rd_valid_r});
    chk("rd_byte", {4'h0, e}, {4'h0, rd_byte_r});
  endtask

  function logic pmap(logic [3:0] m, logic b);
    return (m == `EUS_PLANE_BYPASS) ? 1'b0 :
      (m == `EUS_PLANE_INVERT) ? ~b : b;
  endfunction

  task pix(logic [7:0] opt, logic wr);
    int b;
    if (wr) put(0, `EUS_CMD_RAM_OPT);
    if (wr) put(1, opt);
    for (b = 0; b < 2; b++) begin
      @(negedge mclk);
      ram_red_bit = b[0];
      ram_bw_bit = ~b[0];
      @(negedge mclk);
      chk("red_pix", {11'h0, pmap(opt[7:4], b[0])},
        {11'h0, red_pix_r});
      chk("bw_pix", {11'h0, pmap(opt[3:0], ~b[0])},
        {11'h0, bw_pix_r});
    end
  endtask

  // expected stage list: state of clock and analog seen at each start
  task run(logic [7:0] opt, logic wr);
    logic c, a;
    int i;
    expq.delete();
    seen.delete();
    c = 0;
    a = 0;
    for (i = 7; i >= 0; i--) begin
      if (i != 3 && opt[i]) begin
        expq.push_back({c, a, i[2:0]});
        if (i == 7) c = 1;
        if (i == 0) c = 0;
        if (i == 6) a = 1;
        if (i == 1) a = 0;
      end
    end
    if (wr) put(0, `EUS_CMD_STAGE_OPT);
    if (wr) put(1, opt);
    put(0, `EUS_CMD_ACTIVATE);
    chk("busy_on", 12'h1, {11'h0, busy_r});
    // host stays quiet until busy drops
    i = 0;
    while (busy_r !== 1'b0 && i < 300) begin
      @(negedge mclk);
      i++;
    end
    chk("busy_off", 12'h0, {11'h0, busy_r});
    chk("stage_count", expq.size(), seen.size());
    foreach (expq[k]) chk("stage", {7'h0, expq[k]}, {7'h0, seen[k]});
    chk("clk_an_off", 12'h0, {10'h0, clk_en_r, analog_en_r});
  endtask

  task results;
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, monitor, watchdog
  // ------------------------------------------------------------
  initial forever #10 mclk = ~mclk;

  always @(posedge mclk) begin
    if (stage_go_r === 1'b1) seen.push_back({clk_en_r, analog_en_r,
      stage_code_r});
  end

  initial begin
    #200us;
    n_mismatch++;
    results();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    pix(8'h00, 0);
    put(0, `EUS_CMD_TEMP_RD);
    rd(8'h7f);
    rd(8'hf0);
    put(0, `EUS_CMD_TEMP_WR);
    put(1, 8'h12);
    put(1, 8'h34);
    put(0, `EUS_CMD_TEMP_RD);
    rd(8'h12);
    rd(8'h30);
    run(8'hff, 0);
    // slow stage unit exposes any early advance of the scan
    lat = 4'h5;
    run(8'hc7, 1);
    run(8'h91, 1);
    run(8'hb1, 1);
    put(0, `EUS_CMD_TEMP_RD);
    rd(8'hab);
    rd(8'hc0);
    pix(8'h44, 1);
    pix(8'h88, 1);
    pix(8'h48, 1);
    pix(8'h84, 1);
    pix(8'h08, 1);
    pix(8'h40, 1);
    results();
  end
endmodule
`default_nettype wire
